//--- pkg/cpr_regs.svh
`ifndef CPR_REGS_SVH
`define CPR_REGS_SVH
`define CPR_ADDR_RESET      'h0
`define CPR_MODE_SERIAL     1'b0
`define CPR_MODE_PARALLEL   1'b1
`define CPR_BYTE_BITS       8
`define CPR_BIT_LAST        3'h7
`endif

//--- pkg/cpr_pkg.sv
package cpr_pkg;
  typedef enum logic [1:0] {
    CPR_ST_STANDBY = 2'b00,
    CPR_ST_CLEARED = 2'b01,
    CPR_ST_READING = 2'b10,
    CPR_ST_DONE    = 2'b11
  } cpr_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] data_oe;
  } cpr_data_t;
endpackage : cpr_pkg

//--- hw/cpr_read_counter.sv
// Operation
// R01: driving chip select high puts the device into low-power standby.
// R02: in standby the data output floats whatever the output-enable/clear level.
// R03: enabled and selected below the last address, the address advances each clock, data drives, chain enable stays high; serial steps it every 8th clock.
// R04: past the last address the address freezes, data floats, chain enable goes low, current drops.
// R05: selected with output-enable/clear low, the counter is held clear, data floats, chain enable high.
// R06: deselected, the counter is held clear, data floats, chain enable high, standby current only.
// R07: the last address is the highest array address and the next address wraps to zero.
// R08: the user control bits can be written after the array is programmed without reprogramming it.
// R09: address and bit counters advance on every valid rising configuration clock edge.
// R10: parallel mode delivers one byte per clock, serial mode one bit per clock.
// R11: serial output is the default mode until the control register changes.
`timescale 1ns/10ps
`default_nettype none
`include "cpr_regs.svh"
module cpr_read_counter
  import cpr_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              config_clock,
  input  wire logic              chip_sel_n,
  input  wire logic              oe_clear,
  input  wire logic              ctrl_wr,
  input  wire logic              ctrl_parallel,
  output logic [ADDR_W-1:0]      mem_addr,
  input  wire logic [7:0]        mem_rdata,
  output cpr_data_t              data_out,
  output logic                   chain_enable_out_n,
  output logic                   standby,
  output logic                   low_power
);
  localparam logic [ADDR_W-1:0] LAST_ADDRESS = {ADDR_W{1'b1}};

  logic [2:0] clk_sync_q;
  logic [1:0] cs_sync_q;
  logic [1:0] oe_sync_q;
  logic       cs_n;
  logic       oe;
  logic       clk_rise;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sync_q <= 3'h0;
      cs_sync_q  <= 2'h3;
      oe_sync_q  <= 2'h0;
    end else begin
      clk_sync_q <= {clk_sync_q[1:0], config_clock};
      cs_sync_q  <= {cs_sync_q[0], chip_sel_n};
      oe_sync_q  <= {oe_sync_q[0], oe_clear};
    end
  end
  assign cs_n     = cs_sync_q[1];
  assign oe       = oe_sync_q[1];
  assign clk_rise = clk_sync_q[1] & ~clk_sync_q[2]; // R09

  // control register write is independent of array contents
  logic mode_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= `CPR_MODE_SERIAL; // R11
    end else if (ctrl_wr) begin
      mode_q <= ctrl_parallel; // R08
    end
  end

  cpr_state_t        cur_state;
  logic [ADDR_W-1:0] addr_q;
  logic [2:0]        bit_q;
  logic              done_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= ADDR_W'(`CPR_ADDR_RESET);
      bit_q  <= 3'h0;
      done_q <= 1'b0;
    end else if (cs_n || !oe) begin
      addr_q <= ADDR_W'(`CPR_ADDR_RESET); // R05 R06
      bit_q  <= 3'h0;
      done_q <= 1'b0;
    end else if (clk_rise && !done_q) begin // R03 R09
      if (mode_q == `CPR_MODE_PARALLEL || bit_q == `CPR_BIT_LAST) begin // R10
        bit_q  <= 3'h0;
        addr_q <= addr_q + 1'b1; // R07
        if (addr_q == LAST_ADDRESS) begin
          done_q <= 1'b1; // R04
        end
      end else begin
        bit_q <= bit_q + 3'h1;
      end
    end
  end

  // decode stays combinational so the outputs trail the synchronised pins by one register only
  always_comb begin
    if (cs_n) cur_state = CPR_ST_STANDBY;
    else if (!oe) cur_state = CPR_ST_CLEARED;
    else if (done_q) cur_state = CPR_ST_DONE;
    else cur_state = CPR_ST_READING;
  end

  // bit index travels with mem_addr, so the bit picked always belongs to the byte on mem_rdata
  logic [2:0]        out_bit_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_out           <= '0;
      chain_enable_out_n <= 1'b1;
      standby            <= 1'b1;
      low_power          <= 1'b1;
      mem_addr           <= '0;
      out_bit_q          <= 3'h0;
    end else begin
      mem_addr  <= addr_q;
      out_bit_q <= bit_q;
      case (cur_state)
        CPR_ST_READING: begin
          chain_enable_out_n <= 1'b1; // R03
          standby            <= 1'b0;
          low_power          <= 1'b0;
          if (mode_q == `CPR_MODE_PARALLEL) begin
            data_out <= '{data: mem_rdata, data_oe: 8'hff};
          end else begin
            data_out <= '{data: {7'h00, mem_rdata[out_bit_q]}, data_oe: 8'h01};
          end
        end
        CPR_ST_DONE: begin
          data_out           <= '0; // R04
          chain_enable_out_n <= 1'b0;
          standby            <= 1'b0;
          low_power          <= 1'b1;
        end
        CPR_ST_CLEARED: begin
          data_out           <= '0; // R05
          chain_enable_out_n <= 1'b1;
          standby            <= 1'b0;
          low_power          <= 1'b0;
        end
        default: begin
          data_out           <= '0; // R01 R02 R06
          chain_enable_out_n <= 1'b1;
          standby            <= 1'b1;
          low_power          <= 1'b1;
        end
      endcase
    end
  end

  a_standby_float: assert property (@(posedge mclk) disable iff (!rst_n) // R02
    $past(cs_n) |-> (data_out.data_oe == 8'h00 && standby))
    else $error("data driven in standby");
  a_standby_chain: assert property (@(posedge mclk) disable iff (!rst_n) // R06
    $past(cs_n) |-> chain_enable_out_n)
    else $error("chain enable low in standby");
  a_clear_hold: assert property (@(posedge mclk) disable iff (!rst_n) // R05
    $past(!oe && !cs_n) |-> (addr_q == '0 && data_out.data_oe == 8'h00))
    else $error("counter not held clear");
  a_done_chain: assert property (@(posedge mclk) disable iff (!rst_n) // R04
    $past(done_q && oe && !cs_n) |-> (!chain_enable_out_n && data_out.data_oe == 8'h00))
    else $error("chain enable not low after last address");
  a_done_freeze: assert property (@(posedge mclk) disable iff (!rst_n) // R04
    (done_q && oe && !cs_n) |=> $stable(addr_q))
    else $error("address moved after last");
  a_wrap_zero: assert property (@(posedge mclk) disable iff (!rst_n) // R07
    $rose(done_q) |-> addr_q == '0)
    else $error("address did not wrap");
  a_parallel_step: assert property (@(posedge mclk) disable iff (!rst_n) // R10
    (clk_rise && !done_q && oe && !cs_n && mode_q && !ctrl_wr) |=> addr_q == $past(addr_q) + 1'b1)
    else $error("parallel did not step a byte");
  a_serial_step: assert property (@(posedge mclk) disable iff (!rst_n) // R10
    (clk_rise && !done_q && oe && !cs_n && !mode_q && bit_q != 3'h7) |=>
      (bit_q == $past(bit_q) + 3'h1 && $stable(addr_q)))
    else $error("serial did not step a bit");
  a_read_drive: assert property (@(posedge mclk) disable iff (!rst_n) // R03
    $past(oe && !cs_n && !done_q) |-> (data_out.data_oe != 8'h00 && chain_enable_out_n))
    else $error("data not driven while reading");

  // guards on power, clearing, stepping, output data and the mode register
  a_standby_power: assert property (@(posedge mclk) disable iff (!rst_n) // R01
    $past(cs_n) |-> (standby && low_power))
    else $error("standby not signalled while deselected");
  a_standby_clear: assert property (@(posedge mclk) disable iff (!rst_n) // R06
    $past(cs_n) |-> (addr_q == '0 && bit_q == 3'h0))
    else $error("counter not cleared while deselected");
  a_done_power: assert property (@(posedge mclk) disable iff (!rst_n) // R04
    $past(done_q && oe && !cs_n) |-> (low_power && !standby))
    else $error("supply not reduced after last address");
  a_clear_chain: assert property (@(posedge mclk) disable iff (!rst_n) // R05
    $past(!oe && !cs_n) |-> (chain_enable_out_n && !low_power && !done_q && bit_q == 3'h0))
    else $error("cleared state outputs wrong");
  a_wrap_done: assert property (@(posedge mclk) disable iff (!rst_n) // R07
    (clk_rise && !done_q && oe && !cs_n && addr_q == LAST_ADDRESS &&
      (mode_q || bit_q == 3'h7)) |=> (done_q && addr_q == '0))
    else $error("last address did not end the read");
  a_bit_wrap: assert property (@(posedge mclk) disable iff (!rst_n) // R10
    (clk_rise && !done_q && oe && !cs_n && !mode_q && bit_q == 3'h7) |=>
      (bit_q == 3'h0 && addr_q == $past(addr_q) + 1'b1))
    else $error("serial byte did not end after eight bits");
  a_edge_only: assert property (@(posedge mclk) disable iff (!rst_n) // R09
    (!clk_rise && oe && !cs_n) |=> ($stable(addr_q) && $stable(bit_q)))
    else $error("counter moved without a clock edge");
  a_serial_pin: assert property (@(posedge mclk) disable iff (!rst_n) // R10
    $past(oe && !cs_n && !done_q && !mode_q) |-> data_out.data_oe == 8'h01)
    else $error("serial mode drives more than one pin");
  a_serial_data: assert property (@(posedge mclk) disable iff (!rst_n) // R10
    $past(oe && !cs_n && !done_q && !mode_q) |->
      data_out.data == {7'h00, $past(mem_rdata[out_bit_q])})
    else $error("serial bit not the addressed bit");
  a_parallel_pins: assert property (@(posedge mclk) disable iff (!rst_n) // R10
    $past(oe && !cs_n && !done_q && mode_q) |-> data_out.data_oe == 8'hff)
    else $error("parallel mode leaves pins floating");
  a_parallel_data: assert property (@(posedge mclk) disable iff (!rst_n) // R10
    $past(oe && !cs_n && !done_q && mode_q) |-> data_out.data == $past(mem_rdata))
    else $error("parallel byte not the addressed byte");
  a_mode_write: assert property (@(posedge mclk) disable iff (!rst_n) // R08
    ctrl_wr |=> mode_q == $past(ctrl_parallel))
    else $error("control write did not set the mode");
  a_mode_hold: assert property (@(posedge mclk) disable iff (!rst_n) // R11
    !ctrl_wr |=> $stable(mode_q))
    else $error("mode changed without a control write");
endmodule : cpr_read_counter
`default_nettype wire

//--- bench/cpr_fpga_model.sv
`timescale 1ns/10ps
`default_nettype none
module cpr_fpga_model (
  input  wire logic mclk,
  output logic      config_clock,
  output logic      chip_sel_n,
  output logic      oe_clear
);
  initial begin
    config_clock = 1'b0;
    chip_sel_n   = 1'b1;
    oe_clear     = 1'b0;
  end
  // clock idles low between frames; 6-cycle phases clear the synchroniser margin
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (6) @(posedge mclk);
      config_clock <= 1'b1;
      repeat (6) @(posedge mclk);
      config_clock <= 1'b0;
    end
    repeat (6) @(posedge mclk);
  endtask : pulse
  task automatic ctl(input logic cs_n, input logic oe);
    @(posedge mclk);
    chip_sel_n <= cs_n;
    oe_clear   <= oe;
    repeat (6) @(posedge mclk);
  endtask : ctl
endmodule : cpr_fpga_model
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cpr_pkg::*;
  logic       mclk, rst_n, ctrl_wr, ctrl_parallel;
  logic       config_clock, chip_sel_n, oe_clear, chain_enable_out_n, standby, low_power;
  logic [1:0] mem_addr;
  // bench array: a fixed byte per address, distinct in the low bits
  function automatic logic [7:0] rom_byte(input logic [1:0] a);
    return {6'h00, a} ^ 8'h5a;
  endfunction : rom_byte
  wire  [7:0] mem_rdata = rom_byte(mem_addr);
  cpr_data_t  data_out;
  int         fail_count, n_tests, cyc;
  cpr_fpga_model cpr_fpga_model_i (.mclk(mclk), .config_clock(config_clock),
    .chip_sel_n(chip_sel_n), .oe_clear(oe_clear));
  cpr_read_counter #(.ADDR_W(2)) cpr_read_counter_i (.mclk(mclk), .rst_n(rst_n),
    .config_clock(config_clock), .chip_sel_n(chip_sel_n), .oe_clear(oe_clear),
    .ctrl_wr(ctrl_wr), .ctrl_parallel(ctrl_parallel), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .data_out(data_out), .chain_enable_out_n(chain_enable_out_n),
    .standby(standby), .low_power(low_power));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic serial_read;
    logic [7:0] exp_byte;
    exp_byte = rom_byte(2'h0);
    cpr_fpga_model_i.ctl(1'b0, 1'b1);
    chk(data_out.data_oe, 8'h01);
    for (int i = 0; i < 8; i++) begin
      chk(data_out.data, {7'h00, exp_byte[i]});
      cpr_fpga_model_i.pulse(1);
    end
    exp_byte = rom_byte(2'h1);
    chk(mem_addr, 2'h1);
    chk(data_out.data, {7'h00, exp_byte[0]});
    cpr_fpga_model_i.pulse(23);
    chk({mem_addr, chain_enable_out_n}, 3'h7);
    cpr_fpga_model_i.pulse(1);
    chk({chain_enable_out_n, low_power, data_out.data_oe}, 10'h100);
    cpr_fpga_model_i.pulse(2);
    chk(mem_addr, 2'h0);
  endtask : serial_read
  task automatic parallel_read;
    cpr_fpga_model_i.ctl(1'b0, 1'b0);
    chk({mem_addr, chain_enable_out_n, low_power, data_out.data_oe}, 12'h200);
    set_mode(1'b1);
    cpr_fpga_model_i.ctl(1'b0, 1'b1);
    chk(data_out.data, rom_byte(2'h0));
    cpr_fpga_model_i.pulse(1);
    chk({mem_addr, data_out.data_oe}, 10'h1ff);
    chk(data_out.data, rom_byte(2'h1));
    cpr_fpga_model_i.pulse(3);
    chk({mem_addr, chain_enable_out_n}, 3'h0);
  endtask : parallel_read
  task automatic set_mode(input logic par);
    @(posedge mclk);
    ctrl_wr       <= 1'b1;
    ctrl_parallel <= par;
    @(posedge mclk);
    ctrl_wr <= 1'b0;
  endtask : set_mode
  // reset lands while selected, past the last address and in parallel mode
  task automatic reset_midrun;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    chk({mem_addr, chain_enable_out_n, data_out.data_oe}, 11'h101);
    set_mode(1'b1);
    repeat (3) @(posedge mclk);
    chk(data_out.data_oe, 8'hff);
    set_mode(1'b0);
    repeat (3) @(posedge mclk);
    chk(data_out.data_oe, 8'h01);
  endtask : reset_midrun
  task automatic deselect;
    cpr_fpga_model_i.ctl(1'b1, 1'b1);
    chk({chain_enable_out_n, standby, low_power, data_out.data_oe}, 11'h700);
    cpr_fpga_model_i.ctl(1'b1, 1'b0);
    cpr_fpga_model_i.pulse(1);
    chk({mem_addr, standby, data_out.data_oe}, 11'h100);
  endtask : deselect
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    {rst_n, ctrl_wr, ctrl_parallel, fail_count, n_tests, cyc} = '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    deselect();
    serial_read();
    parallel_read();
    reset_midrun();
    deselect();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
